// ### src/gif_pkg.sv
// Package with register layout, offsets and reset values of the graphics event flags.
// Summary of operation
// - Bit 15 is OR of unit done flags.
// - Summary reads one when any unit finished.
// - Bits 14 to 8 read zero, ignore writes.
// - Inflate done sets bit 7, held.
// - Rect copy done sets bit 6, held.
// - Character unit done sets bit 5, held.
// - Vertical blanking sets bit 4, held.
// - Flags reset zero, hardware set, software writable.
// - Horizontal blanking sets bit 3, held.
// - Command watermark sets bit 2, held.
package gif_pkg;
	localparam int GIF_AW = 4;
	localparam logic [3:0] GIF_OFS_FLAGS = 4'h0;
	localparam logic [3:0] GIF_OFS_MASK = 4'h4;
	localparam logic [3:0] GIF_OFS_PEND = 4'h8;
	localparam int GIF_BIT_ANY = 15;
	localparam int GIF_BIT_INFLATE = 7;
	localparam int GIF_BIT_RECT = 6;
	localparam int GIF_BIT_CHAR = 5;
	localparam int GIF_BIT_VBLANK = 4;
	localparam int GIF_BIT_HBLANK = 3;
	localparam int GIF_BIT_WMARK = 2;
	localparam int GIF_BIT_FULL = 1;
	localparam int GIF_BIT_EMPTY = 0;
	localparam int GIF_NEV = 8;
	localparam logic [15:0] GIF_FLAGS_RST = 16'h0000;
	localparam logic [7:0] GIF_MASK_RST = 8'h00;
	localparam logic [15:0] GIF_IMPL_BITS = 16'h80ff;
endpackage

// ### src/gif_flags.sv
// Graphics event flag register with a classic Wishbone slave and masked interrupt.
module gif_flags
	import gif_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [GIF_AW-1:0] I_WB_ADR,
	input wire logic [31:0] I_WB_DAT,
	input wire logic [3:0] I_WB_SEL,
	input wire logic I_WB_WE,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	input wire logic [GIF_NEV-1:0] I_EVENT,
	output logic O_IRQ
);
	typedef struct packed {
		logic [GIF_NEV-1:0] flags;
		logic [GIF_NEV-1:0] pend;
		logic [GIF_NEV-1:0] mask;
		logic ack;
		logic [31:0] rdat;
	} gif_state_s;

	gif_state_s st_r;
	gif_state_s st_nxt;
	logic req;
	logic wr;
	logic rd;
	logic [15:0] flag_view;

	assign req = I_WB_CYC && I_WB_STB && !st_r.ack;
	assign wr = req && I_WB_WE;
	assign rd = req && !I_WB_WE;

	always_comb
	begin
		flag_view = 16'h0000;
		flag_view[GIF_NEV-1:0] = st_r.flags;
		flag_view[GIF_BIT_ANY] = st_r.flags[GIF_BIT_INFLATE] | st_r.flags[GIF_BIT_RECT]
			| st_r.flags[GIF_BIT_CHAR];
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ack = req;
		// Software writes first, hardware sets afterwards so a set in the same cycle wins.
		if (wr && I_WB_ADR == GIF_OFS_FLAGS && I_WB_SEL[0])
		begin
			st_nxt.flags = I_WB_DAT[GIF_NEV-1:0];
		end
		if (wr && I_WB_ADR == GIF_OFS_MASK && I_WB_SEL[0])
		begin
			st_nxt.mask = I_WB_DAT[GIF_NEV-1:0];
		end
		if (rd && I_WB_ADR == GIF_OFS_PEND)
		begin
			st_nxt.pend = '0;
		end
		st_nxt.flags = st_nxt.flags | I_EVENT;
		st_nxt.pend = st_nxt.pend | I_EVENT;
		st_nxt.rdat = 32'h0000_0000;
		if (rd)
		begin
			case (I_WB_ADR)
				GIF_OFS_FLAGS: st_nxt.rdat = {16'h0000, flag_view & GIF_IMPL_BITS};
				GIF_OFS_MASK: st_nxt.rdat = {24'h000000, st_r.mask};
				GIF_OFS_PEND: st_nxt.rdat = {24'h000000, st_r.pend};
				default: st_nxt.rdat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			st_r.flags <= GIF_FLAGS_RST[GIF_NEV-1:0];
			st_r.pend <= '0;
			st_r.mask <= GIF_MASK_RST;
			st_r.ack <= 1'b0;
			st_r.rdat <= 32'h0000_0000;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign O_WB_DAT = st_r.rdat;
	assign O_WB_ACK = st_r.ack;
	assign O_IRQ = |(st_r.pend & st_r.mask);

	flag_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_INFLATE] |=> st_r.flags[GIF_BIT_INFLATE])
		else $error("Inflate event did not set its flag.");
	rect_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_RECT] |=> st_r.flags[GIF_BIT_RECT])
		else $error("Rect copy event did not set its flag.");
	char_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_CHAR] |=> st_r.flags[GIF_BIT_CHAR])
		else $error("Character event did not set its flag.");
	vblank_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.flags[GIF_BIT_VBLANK] && !(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> st_r.flags[GIF_BIT_VBLANK])
		else $error("Vertical blank flag dropped without a write.");
	hblank_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_HBLANK] |=> st_r.flags[GIF_BIT_HBLANK])
		else $error("Horizontal blank event did not set its flag.");
	wmark_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_WMARK] |=> st_r.flags[GIF_BIT_WMARK])
		else $error("Watermark event did not set its flag.");
	fifo_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_FULL] && I_EVENT[GIF_BIT_EMPTY]
		|=> st_r.flags[GIF_BIT_FULL] && st_r.flags[GIF_BIT_EMPTY])
		else $error("FIFO event did not set its flag.");
	summary_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rd && I_WB_ADR == GIF_OFS_FLAGS |=> O_WB_ACK
		&& O_WB_DAT[GIF_BIT_ANY] == |$past(st_r.flags[GIF_BIT_INFLATE:GIF_BIT_CHAR])
		&& O_WB_DAT[14:8] == 7'h00)
		else $error("Summary or unused bits read wrong.");
	write_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr && I_WB_ADR == GIF_OFS_FLAGS && I_WB_SEL[0] && I_EVENT == 8'h00
		|=> st_r.flags == $past(I_WB_DAT[GIF_NEV-1:0]))
		else $error("Software write did not store the flags.");
	reset_zero_a: assert property (@(posedge I_CLK)
		I_RST |=> st_r.flags == 8'h00 && !O_IRQ)
		else $error("Flags not zero after reset.");

	// The checks below cover every flag bit, the pending copy, the mask and the bus timing.
	// Events are sampled as levels, so a long blanking level keeps its flag set each cycle.
	vblank_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_VBLANK]
		|=> st_r.flags[GIF_BIT_VBLANK])
		else $error("Vertical blank event did not set its flag.");

	full_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_FULL]
		|=> st_r.flags[GIF_BIT_FULL])
		else $error("FIFO full event did not set its flag.");

	empty_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[GIF_BIT_EMPTY]
		|=> st_r.flags[GIF_BIT_EMPTY])
		else $error("FIFO empty event did not set its flag.");

	inflate_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.flags[GIF_BIT_INFLATE] && !(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> st_r.flags[GIF_BIT_INFLATE])
		else $error("Inflate flag dropped without a write.");

	rect_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.flags[GIF_BIT_RECT] && !(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> st_r.flags[GIF_BIT_RECT])
		else $error("Rect copy flag dropped without a write.");

	char_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.flags[GIF_BIT_CHAR] && !(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> st_r.flags[GIF_BIT_CHAR])
		else $error("Character flag dropped without a write.");

	hblank_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.flags[GIF_BIT_HBLANK] && !(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> st_r.flags[GIF_BIT_HBLANK])
		else $error("Horizontal blank flag dropped without a write.");

	wmark_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.flags[GIF_BIT_WMARK] && !(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> st_r.flags[GIF_BIT_WMARK])
		else $error("Watermark flag dropped without a write.");

	full_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.flags[GIF_BIT_FULL] && !(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> st_r.flags[GIF_BIT_FULL])
		else $error("FIFO full flag dropped without a write.");

	empty_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.flags[GIF_BIT_EMPTY] && !(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> st_r.flags[GIF_BIT_EMPTY])
		else $error("FIFO empty flag dropped without a write.");

	flags_no_rise_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!(wr && I_WB_ADR == GIF_OFS_FLAGS)
		|=> (st_r.flags & ~$past(st_r.flags | I_EVENT)) == 8'h00)
		else $error("A flag rose without an event or a write.");

	write_merge_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr && I_WB_ADR == GIF_OFS_FLAGS && I_WB_SEL[0]
		|=> st_r.flags == ($past(I_WB_DAT[GIF_NEV-1:0]) | $past(I_EVENT)))
		else $error("Flag write did not merge with same-cycle events.");

	write_sel_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr && I_WB_ADR == GIF_OFS_FLAGS && !I_WB_SEL[0]
		|=> st_r.flags == $past(st_r.flags | I_EVENT))
		else $error("Flag write without its byte lane changed the flags.");

	set_wins_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr && I_WB_ADR == GIF_OFS_FLAGS && I_EVENT != 8'h00
		|=> (st_r.flags & $past(I_EVENT)) == $past(I_EVENT))
		else $error("A clearing write beat a same-cycle event.");

	mask_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr && I_WB_ADR == GIF_OFS_MASK && I_WB_SEL[0]
		|=> st_r.mask == $past(I_WB_DAT[GIF_NEV-1:0]))
		else $error("Mask write was not stored.");

	mask_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!(wr && I_WB_ADR == GIF_OFS_MASK && I_WB_SEL[0])
		|=> $stable(st_r.mask))
		else $error("Mask changed without a write.");

	pend_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT != 8'h00
		|=> (st_r.pend & $past(I_EVENT)) == $past(I_EVENT))
		else $error("Event did not set its pending bit.");

	pend_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rd && I_WB_ADR == GIF_OFS_PEND
		|=> st_r.pend == $past(I_EVENT))
		else $error("Reading pending did not clear it.");

	pend_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!(rd && I_WB_ADR == GIF_OFS_PEND)
		|=> st_r.pend == $past(st_r.pend | I_EVENT))
		else $error("Pending bits changed without an event or a read.");

	irq_rise_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT & st_r.mask) != 8'h00 && !(wr && I_WB_ADR == GIF_OFS_MASK)
		|=> O_IRQ)
		else $error("Unmasked event did not raise the interrupt.");

	irq_masked_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.mask == 8'h00
		|-> !O_IRQ)
		else $error("Interrupt raised with every source masked.");

	ack_pulse_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_WB_ACK
		|=> !O_WB_ACK)
		else $error("Acknowledge stood longer than one cycle.");

	ack_follow_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		req
		|=> O_WB_ACK)
		else $error("Request was not acknowledged in the next cycle.");

	ack_only_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!(I_WB_CYC && I_WB_STB)
		|=> !O_WB_ACK)
		else $error("Acknowledge given without a request.");

	rdat_idle_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!rd
		|=> O_WB_DAT == 32'h0000_0000)
		else $error("Read data not zero outside a read.");

	upper_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		1'b1
		|-> O_WB_DAT[31:16] == 16'h0000)
		else $error("Upper half of read data not zero.");

	unused_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		1'b1
		|-> O_WB_DAT[14:8] == 7'h00)
		else $error("Unimplemented flag bits read nonzero.");

	flags_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rd && I_WB_ADR == GIF_OFS_FLAGS
		|=> O_WB_DAT[GIF_NEV-1:0] == $past(st_r.flags))
		else $error("Flag read returned wrong low byte.");

	mask_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rd && I_WB_ADR == GIF_OFS_MASK
		|=> O_WB_DAT == {24'h000000, $past(st_r.mask)})
		else $error("Mask read returned wrong data.");

	pend_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rd && I_WB_ADR == GIF_OFS_PEND
		|=> O_WB_DAT == {24'h000000, $past(st_r.pend)})
		else $error("Pending read returned wrong data.");

	unmapped_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rd && I_WB_ADR != GIF_OFS_FLAGS && I_WB_ADR != GIF_OFS_MASK && I_WB_ADR != GIF_OFS_PEND
		|=> O_WB_DAT == 32'h0000_0000)
		else $error("Unmapped read returned nonzero data.");

	unmapped_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		wr && I_WB_ADR != GIF_OFS_FLAGS && I_WB_ADR != GIF_OFS_MASK
		|=> st_r.flags == $past(st_r.flags | I_EVENT) && $stable(st_r.mask))
		else $error("Unmapped write changed a register.");

	summary_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rd && I_WB_ADR == GIF_OFS_FLAGS && st_r.flags[GIF_BIT_INFLATE:GIF_BIT_CHAR] == 3'b000
		|=> !O_WB_DAT[GIF_BIT_ANY])
		else $error("Summary flag read one with every unit idle.");

	summary_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		rd && I_WB_ADR == GIF_OFS_FLAGS && st_r.flags[GIF_BIT_INFLATE:GIF_BIT_CHAR] != 3'b000
		|=> O_WB_DAT[GIF_BIT_ANY])
		else $error("Summary flag read zero with a unit finished.");

	reset_mask_a: assert property (@(posedge I_CLK)
		I_RST
		|=> st_r.mask == 8'h00 && st_r.pend == 8'h00 && !O_WB_ACK)
		else $error("Mask, pending or acknowledge not zero after reset.");

	reset_data_a: assert property (@(posedge I_CLK)
		I_RST
		|=> O_WB_DAT == 32'h0000_0000)
		else $error("Read data not zero after reset.");
endmodule

// ### verification/tb.sv
// Self-checking bench for the graphics event flag register and its interrupt.
module tb
	import gif_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic I_CLK = 0, I_RST = 1, I_WB_WE = 0, I_WB_CYC = 0, I_WB_STB = 0, O_WB_ACK, O_IRQ;
	logic [3:0] I_WB_ADR = 4'h0, I_WB_SEL = 4'hf;
	logic [31:0] I_WB_DAT = 32'h0, O_WB_DAT, rd;
	logic [7:0] I_EVENT = 8'h00;
	int n_fail = 0, samples_checked = 0;
	gif_flags dut (.I_CLK, .I_RST, .I_WB_ADR, .I_WB_DAT, .I_WB_SEL, .I_WB_WE, .I_WB_CYC,
		.I_WB_STB, .O_WB_DAT, .O_WB_ACK, .I_EVENT, .O_IRQ);
	always #25 I_CLK = ~I_CLK;
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Holds the request until ack is seen at an edge, so the answer is never missed.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		{I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_DAT} <= {2'b11, w, a, d};
		i = 0;
		do
		begin
			@(posedge I_CLK);
			i++;
		end
		while (O_WB_ACK !== 1'b1 && i < 20);
		if (i == 20)
		begin
			n_fail++;
			wrap_up();
		end
		rd = O_WB_DAT;
		{I_WB_CYC, I_WB_STB} <= 2'b00;
		@(posedge I_CLK);
	endtask
	task automatic ev(input logic [7:0] v);
		I_EVENT <= v;
		@(posedge I_CLK);
		I_EVENT <= 8'h00;
		@(posedge I_CLK);
	endtask
	task automatic t_flags();
		logic [15:0] e;
		wb(1'b0, GIF_OFS_FLAGS, 32'h0);
		chk("flags reset", 32'h0, rd);
		for (int b = 0; b < GIF_NEV; b++)
		begin
			e = 16'h0001 << b;
			e[GIF_BIT_ANY] = (b >= GIF_BIT_CHAR);
			ev(e[7:0]);
			wb(1'b0, GIF_OFS_FLAGS, 32'h0);
			chk("flag", {16'h0, e}, rd);
			wb(1'b1, GIF_OFS_FLAGS, 32'h0);
		end
		wb(1'b1, GIF_OFS_FLAGS, 32'hff7f);
		wb(1'b0, GIF_OFS_FLAGS, 32'h0);
		chk("flags written", 32'h807f, rd);
		wb(1'b1, GIF_OFS_FLAGS, 32'h10);
		wb(1'b0, GIF_OFS_FLAGS, 32'h0);
		chk("summary idle", 32'h0010, rd);
		wb(1'b1, 4'hc, 32'hff);
		wb(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask
	task automatic t_irq();
		wb(1'b0, GIF_OFS_PEND, 32'h0);
		wb(1'b1, GIF_OFS_MASK, 32'h01);
		wb(1'b0, GIF_OFS_MASK, 32'h0);
		chk("mask", 32'h01, rd);
		ev(8'h02);
		@(posedge I_CLK);
		chk("irq masked", 32'h0, {31'h0, O_IRQ});
		ev(8'h01);
		@(posedge I_CLK);
		chk("irq raised", 32'h1, {31'h0, O_IRQ});
		wb(1'b0, GIF_OFS_PEND, 32'h0);
		chk("pending", 32'h03, rd);
		@(posedge I_CLK);
		chk("irq cleared", 32'h0, {31'h0, O_IRQ});
	endtask
	initial
	begin
		repeat (5) @(posedge I_CLK);
		I_RST <= 1'b0;
		@(posedge I_CLK);
		t_flags();
		t_irq();
		wrap_up();
	end
endmodule
